//--- hdl/phy_misc_status_config_regs.sv
// Misc configuration and status register bank with idle detector and checker byte counter.
//
// Functional notes
// - Idle mode after threshold consecutive idles, reset 5.
// - Skew register shows channel A and B delays.
// - Strap one bits 15..7 show strap flags.
// - Strap one: select bit 5, address 3:0.
// - Strap two bit 10 shows fast link drop.
// - Strap two shows transmit and receive delay codes.
// - Sixteen bit checker byte count, reset zero.
// - Readable count frozen on lock or clear write.
// - Count saturates at all ones when mode zero.
// - Clear write locks, zeroes counters and overflow flags.
// - Byte overflow flag reads one until cleared.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module phy_misc_status_config_regs (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [phy_misc_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [phy_misc_pkg::DATA_W-1:0] pwdata_in,
  output logic [phy_misc_pkg::DATA_W-1:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Strap pins, asynchronous to the clock.
  input wire phy_misc_pkg::strap_pins_s strap_pins_in,
  // Receive symbol stream from the Viterbi detector.
  input wire logic symbol_valid_in,
  input wire logic symbol_idle_in,
  // Channel alignment delays from the receive aligner.
  input wire logic [3:0] chan_a_alignment_cycles_in,
  input wire logic [3:0] chan_b_alignment_cycles_in,
  // Byte strobe from the checker.
  input wire logic checker_byte_valid_in,
  // Results towards the rest of the transceiver.
  output logic idle_mode_out,
  output logic [3:0] idle_symbol_threshold_out,
  output phy_misc_pkg::strap_pins_s strap_held_out,
  output logic strap_valid_out,
  output logic [15:0] checker_byte_total_out,
  output logic checker_byte_total_overflow_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.
  phy_misc_pkg::state_s state_reg;
  phy_misc_pkg::state_s state_next;
  logic [$bits(phy_misc_pkg::strap_pins_s)-1:0] strap_sync_bits;
  phy_misc_pkg::strap_pins_s strap_synced;
  logic [phy_misc_pkg::IDX_W-1:0] reg_idx;
  logic setup_phase;
  logic write_fire;
  logic [phy_misc_pkg::REG_W-1:0] read_word;
  logic read_hit;
  phy_misc_pkg::viterbi_idle_config_s viterbi_view;
  phy_misc_pkg::rx_channel_skew_status_s skew_view;
  phy_misc_pkg::strap_status_one_s strap_one_view;
  phy_misc_pkg::strap_status_two_s strap_two_view;
  phy_misc_pkg::prbs_control_status_two_s ctl_two_view;
  phy_misc_pkg::prbs_control_status_two_s ctl_two_write;
  phy_misc_pkg::checker_mode_s mode_view;
  phy_misc_pkg::checker_mode_s mode_write;
  phy_misc_pkg::viterbi_idle_config_s viterbi_write;
  logic lock_req;
  logic clear_req;
  logic byte_at_max;
  logic byte_ovf_event;

  //////////////////////////////////////////////////////////////////////////////
  // Strap synchronisation.

  // Strap pins come from outside and pass two flip-flops first.
  strap_sync #(
    .W($bits(phy_misc_pkg::strap_pins_s))
  ) u_strap_sync (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(strap_pins_in),
    .sync_out(strap_sync_bits)
  );

  assign strap_synced = phy_misc_pkg::strap_pins_s'(strap_sync_bits);

  //////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // Word index and the two phases of an APB transfer.
  assign reg_idx = paddr_in[phy_misc_pkg::ADDR_W-1:2];
  assign setup_phase = psel_in && !penable_in;
  assign write_fire = psel_in && penable_in && pwrite_in && state_reg.pready;

  // Write data seen through each writable layout.
  assign viterbi_write = phy_misc_pkg::viterbi_idle_config_s'(pwdata_in[phy_misc_pkg::REG_W-1:0]);
  assign ctl_two_write = phy_misc_pkg::prbs_control_status_two_s'(pwdata_in[phy_misc_pkg::REG_W-1:0]);
  assign mode_write = phy_misc_pkg::checker_mode_s'(pwdata_in[phy_misc_pkg::REG_W-1:0]);

  //////////////////////////////////////////////////////////////////////////////
  // Register views.

  always_comb begin
    viterbi_view = '0;
    viterbi_view.rsvd = phy_misc_pkg::VITERBI_RSVD_VALUE;
    viterbi_view.idle_symbol_threshold = state_reg.idle_thr;
  end

  always_comb begin
    skew_view = '0;
    skew_view.chan_a_alignment_cycles = chan_a_alignment_cycles_in;
    skew_view.chan_b_alignment_cycles = chan_b_alignment_cycles_in;
  end

  always_comb begin
    strap_one_view = '0;
    strap_one_view.mirror_en = state_reg.strap_held.mirror_en;
    strap_one_view.downshift_en = state_reg.strap_held.downshift_en;
    strap_one_view.strapped_clock_output_off = state_reg.strap_held.clock_output_off;
    strap_one_view.strapped_reduced_gmii_off = state_reg.strap_held.reduced_gmii_off;
    strap_one_view.sgmii_en = state_reg.strap_held.sgmii_en;
    strap_one_view.strapped_auto_crossover_off = state_reg.strap_held.auto_crossover_off;
    strap_one_view.strapped_forced_crossover = state_reg.strap_held.forced_crossover;
    strap_one_view.strapped_half_duplex = state_reg.strap_held.half_duplex;
    strap_one_view.strapped_autoneg_off = state_reg.strap_held.autoneg_off;
    strap_one_view.strapped_autoneg_select = state_reg.strap_held.autoneg_select;
    strap_one_view.strapped_mgmt_address = state_reg.strap_held.mgmt_address;
  end

  always_comb begin
    strap_two_view = '0;
    strap_two_view.strapped_fast_link_drop = state_reg.strap_held.fast_link_drop;
    strap_two_view.tx_clock_delay = state_reg.strap_held.tx_clock_delay;
    strap_two_view.rx_clock_delay = state_reg.strap_held.rx_clock_delay;
  end

  always_comb begin
    ctl_two_view = '0;
    ctl_two_view.checker_byte_total_overflow = state_reg.byte_ovf;
  end

  // Count wrap select readback.
  always_comb begin
    mode_view = '0;
    mode_view.checker_count_wrap_select = state_reg.wrap_sel;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read multiplexer.

  // Selects the addressed register; unmapped words read zero with an error.
  always_comb begin
    read_word = '0;
    read_hit = 1'b1;
    case (reg_idx)
      phy_misc_pkg::IDX_VITERBI_IDLE_CONFIG: begin
        read_word = viterbi_view;
      end
      phy_misc_pkg::IDX_RX_CHANNEL_SKEW_STATUS: begin
        read_word = skew_view;
      end
      phy_misc_pkg::IDX_STRAP_STATUS_ONE: begin
        read_word = strap_one_view;
      end
      phy_misc_pkg::IDX_STRAP_STATUS_TWO: begin
        read_word = strap_two_view;
      end
      phy_misc_pkg::IDX_PRBS_RECEIVED_BYTE_COUNT: begin
        read_word = state_reg.byte_snap;
      end
      phy_misc_pkg::IDX_PRBS_CONTROL_STATUS_TWO: begin
        read_word = ctl_two_view;
      end
      phy_misc_pkg::IDX_CHECKER_MODE: begin
        read_word = mode_view;
      end
      default: begin
        read_hit = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter control terms.

  // Lock and clear pulses from a completed write to the second control register.
  assign lock_req = write_fire && (reg_idx == phy_misc_pkg::IDX_PRBS_CONTROL_STATUS_TWO) &&
                    (ctl_two_write.lock_counters || ctl_two_write.clear_counters);
  assign clear_req = write_fire && (reg_idx == phy_misc_pkg::IDX_PRBS_CONTROL_STATUS_TWO) &&
                     ctl_two_write.clear_counters;

  // An increment at the top value overflows.
  assign byte_at_max = (state_reg.byte_live == phy_misc_pkg::BYTE_COUNT_MAX);
  assign byte_ovf_event = checker_byte_valid_in && byte_at_max;

  //////////////////////////////////////////////////////////////////////////////
  // Next state.

  // Computes the whole next state of the bank.
  always_comb begin
    state_next = state_reg;

    // Bus answer: data and status are captured in the setup cycle.
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    if (setup_phase) begin
      state_next.pready = 1'b1;
      state_next.pslverr = !read_hit;
      state_next.prdata = '0;
      state_next.prdata[phy_misc_pkg::REG_W-1:0] = read_word;
    end

    case (state_reg.strap_phase)
      phy_misc_pkg::STRAP_SETTLE: begin
        if (state_reg.settle_cnt == phy_misc_pkg::STRAP_SETTLE_CYCLES) begin
          state_next.strap_held = strap_synced;
          state_next.strap_phase = phy_misc_pkg::STRAP_HELD;
        end else begin
          state_next.settle_cnt = 2'(state_reg.settle_cnt + phy_misc_pkg::SETTLE_STEP);
        end
      end
      phy_misc_pkg::STRAP_HELD: begin
        state_next.strap_held = state_reg.strap_held;
      end
      default: begin
        state_next.strap_phase = phy_misc_pkg::STRAP_SETTLE;
      end
    endcase

    if (write_fire && (reg_idx == phy_misc_pkg::IDX_VITERBI_IDLE_CONFIG)) begin
      state_next.idle_thr = viterbi_write.idle_symbol_threshold;
    end

    // Count wrap select write.
    if (write_fire && (reg_idx == phy_misc_pkg::IDX_CHECKER_MODE)) begin
      state_next.wrap_sel = mode_write.checker_count_wrap_select;
    end

    if (symbol_valid_in) begin
      if (symbol_idle_in) begin
        if (state_reg.idle_run != phy_misc_pkg::IDLE_RUN_MAX) begin
          state_next.idle_run = 4'(state_reg.idle_run + phy_misc_pkg::IDLE_RUN_ONE);
        end
        state_next.idle_mode = (state_next.idle_run >= state_reg.idle_thr);
      end else begin
        state_next.idle_run = '0;
        state_next.idle_mode = 1'b0;
      end
    end

    if (lock_req) begin
      state_next.byte_snap = state_reg.byte_live;
    end

    // byte counting; saturate when wrap select is zero.
    if (clear_req) begin
      // clear restarts from zero, counting a byte of this cycle.
      state_next.byte_live = checker_byte_valid_in ? phy_misc_pkg::BYTE_COUNT_ONE :
                                                     phy_misc_pkg::BYTE_COUNT_RESET;
    end else if (checker_byte_valid_in) begin
      if (!byte_at_max) begin
        state_next.byte_live = 16'(state_reg.byte_live + phy_misc_pkg::BYTE_COUNT_ONE);
      end else if (state_reg.wrap_sel) begin
        state_next.byte_live = phy_misc_pkg::BYTE_COUNT_RESET;
      end
    end

    // overflow sticky; set wins over clear.
    state_next.byte_ovf = (clear_req ? 1'b0 : state_reg.byte_ovf) || byte_ovf_event;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.

  // Synchronous reset loads constants only.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_reg <= '0;
      state_reg.strap_phase <= phy_misc_pkg::STRAP_SETTLE;
      state_reg.idle_thr <= phy_misc_pkg::IDLE_THR_RESET;
      state_reg.byte_live <= phy_misc_pkg::BYTE_COUNT_RESET;
      state_reg.byte_snap <= phy_misc_pkg::BYTE_COUNT_RESET;
      state_reg.wrap_sel <= phy_misc_pkg::CHECKER_WRAP_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // Bus outputs; ready is high in the first access cycle.
  assign prdata_out = state_reg.prdata;
  assign pready_out = state_reg.pready;
  assign pslverr_out = state_reg.pslverr && state_reg.pready;

  // Block results, all from flip-flops.
  assign idle_mode_out = state_reg.idle_mode;
  assign idle_symbol_threshold_out = state_reg.idle_thr;
  assign strap_held_out = state_reg.strap_held;
  assign strap_valid_out = (state_reg.strap_phase == phy_misc_pkg::STRAP_HELD);
  assign checker_byte_total_out = state_reg.byte_live;
  assign checker_byte_total_overflow_out = state_reg.byte_ovf;

endmodule

`default_nettype wire

//--- hdl/phy_misc_pkg.sv
// Package with register map, field layouts and state layout of the misc register bank.
package phy_misc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Bus widths.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int IDX_W = 10;

  //////////////////////////////////////////////////////////////////////////////
  // Register indices; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_VITERBI_IDLE_CONFIG = 10'h053;
  localparam logic [IDX_W-1:0] IDX_RX_CHANNEL_SKEW_STATUS = 10'h055;
  localparam logic [IDX_W-1:0] IDX_STRAP_STATUS_ONE = 10'h06E;
  localparam logic [IDX_W-1:0] IDX_STRAP_STATUS_TWO = 10'h06F;
  localparam logic [IDX_W-1:0] IDX_PRBS_RECEIVED_BYTE_COUNT = 10'h071;
  localparam logic [IDX_W-1:0] IDX_PRBS_CONTROL_STATUS_TWO = 10'h072;
  localparam logic [IDX_W-1:0] IDX_CHECKER_MODE = 10'h07E;

  //////////////////////////////////////////////////////////////////////////////
  // Reset and fixed values.
  localparam logic [3:0] IDLE_THR_RESET = 4'h5;
  localparam logic [11:0] VITERBI_RSVD_VALUE = 12'h205;
  localparam logic [15:0] BYTE_COUNT_RESET = 16'h0000;
  localparam logic [15:0] BYTE_COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] BYTE_COUNT_ONE = 16'h0001;
  localparam logic [3:0] IDLE_RUN_MAX = 4'hF;
  localparam logic [3:0] IDLE_RUN_ONE = 4'h1;
  localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;
  localparam logic [1:0] SETTLE_STEP = 2'h1;
  localparam logic CHECKER_WRAP_RESET = 1'b0;

  //////////////////////////////////////////////////////////////////////////////
  // Strap pins as they arrive at the block.
  typedef struct packed {
    logic mirror_en;
    logic downshift_en;
    logic clock_output_off;
    logic reduced_gmii_off;
    logic sgmii_en;
    logic auto_crossover_off;
    logic forced_crossover;
    logic half_duplex;
    logic autoneg_off;
    logic autoneg_select;
    logic fast_link_drop;
    logic [3:0] mgmt_address;
    logic [2:0] tx_clock_delay;
    logic [2:0] rx_clock_delay;
  } strap_pins_s;

  //////////////////////////////////////////////////////////////////////////////
  // Register layouts, most significant bit first.
  typedef struct packed {
    logic [11:0] rsvd;
    logic [3:0] idle_symbol_threshold;
  } viterbi_idle_config_s;

  typedef struct packed {
    logic [7:0] rsvd;
    logic [3:0] chan_b_alignment_cycles;
    logic [3:0] chan_a_alignment_cycles;
  } rx_channel_skew_status_s;

  typedef struct packed {
    logic mirror_en;
    logic downshift_en;
    logic strapped_clock_output_off;
    logic strapped_reduced_gmii_off;
    logic sgmii_en;
    logic strapped_auto_crossover_off;
    logic strapped_forced_crossover;
    logic strapped_half_duplex;
    logic strapped_autoneg_off;
    logic rsvd6;
    logic strapped_autoneg_select;
    logic rsvd4;
    logic [3:0] strapped_mgmt_address;
  } strap_status_one_s;

  typedef struct packed {
    logic [4:0] rsvd15_11;
    logic strapped_fast_link_drop;
    logic [2:0] rsvd9_7;
    logic [2:0] tx_clock_delay;
    logic rsvd3;
    logic [2:0] rx_clock_delay;
  } strap_status_two_s;

  typedef struct packed {
    logic [4:0] rsvd15_11;
    logic checker_packet_total_overflow;
    logic checker_byte_total_overflow;
    logic rsvd8;
    logic [5:0] rsvd7_2;
    logic clear_counters;
    logic lock_counters;
  } prbs_control_status_two_s;

  typedef struct packed {
    logic [14:0] rsvd;
    logic checker_count_wrap_select;
  } checker_mode_s;

  //////////////////////////////////////////////////////////////////////////////
  // Strap capture phases.
  typedef enum logic [1:0] {
    STRAP_SETTLE = 2'h0,
    STRAP_HELD = 2'h1
  } strap_phase_e;

  //////////////////////////////////////////////////////////////////////////////
  // Whole state of the register bank.
  typedef struct packed {
    strap_phase_e strap_phase;
    logic [1:0] settle_cnt;
    strap_pins_s strap_held;
    logic [3:0] idle_thr;
    logic [3:0] idle_run;
    logic idle_mode;
    logic [15:0] byte_live;
    logic [15:0] byte_snap;
    logic byte_ovf;
    logic wrap_sel;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;

endpackage

//--- hdl/strap_sync.sv
// Two flip-flop synchroniser for a group of level inputs.
`timescale 1ns/1ps
`default_nettype none

module strap_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // The first stage feeds only the second stage.
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule

`default_nettype wire

//--- tb/phy_misc_status_config_regs_properties.sv
// Checker of bus timing, counter and idle behaviour of the misc register bank.
`timescale 1ns/1ps
`default_nettype none

module phy_misc_status_config_regs_checker (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [phy_misc_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [phy_misc_pkg::DATA_W-1:0] pwdata_in,
  input wire logic [phy_misc_pkg::DATA_W-1:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic symbol_valid_in,
  input wire logic symbol_idle_in,
  input wire logic checker_byte_valid_in,
  input wire logic idle_mode_out,
  input wire logic [3:0] idle_symbol_threshold_out,
  input wire phy_misc_pkg::strap_pins_s strap_held_out,
  input wire logic strap_valid_out,
  input wire logic [15:0] checker_byte_total_out,
  input wire logic checker_byte_total_overflow_out
);
  default clocking cb @(posedge ref_clk_in);
  endclocking

  // Completed write that sets the clear bit of the checker control register.
  logic clr_wr;
  assign clr_wr = psel_in && penable_in && pwrite_in && pready_out && pwdata_in[1]
    && (paddr_in[11:2] == phy_misc_pkg::IDX_PRBS_CONTROL_STATUS_TWO);

  // Bus setup cycle followed by a single answer cycle.
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_answer;
    pready_out ##1 !pready_out;
  endsequence

  property p_answer;
    disable iff (!rst_n_in) s_setup |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("answer not one cycle after setup");
  property p_err_ready;
    disable iff (!rst_n_in) pslverr_out |-> pready_out && prdata_out == 32'h00000000;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready or with data");
  property p_reset_vals;
    !rst_n_in |=> idle_symbol_threshold_out == 4'h5 && checker_byte_total_out == 16'h0000
      && !checker_byte_total_overflow_out && !idle_mode_out;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("wrong value after reset");
  property p_count_up;
    disable iff (!rst_n_in) checker_byte_valid_in && checker_byte_total_out != 16'hFFFF && !clr_wr
      |=> checker_byte_total_out == $past(checker_byte_total_out) + 16'h0001;
  endproperty
  a_count_up: assert property (p_count_up) else $error("byte count did not step");
  property p_count_hold;
    disable iff (!rst_n_in) !checker_byte_valid_in && !clr_wr |=> $stable(checker_byte_total_out);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("byte count moved without a byte");
  property p_ovf_set;
    disable iff (!rst_n_in) checker_byte_valid_in && checker_byte_total_out == 16'hFFFF
      |=> checker_byte_total_overflow_out;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");
  property p_ovf_sticky;
    disable iff (!rst_n_in) checker_byte_total_overflow_out && !clr_wr |=> checker_byte_total_overflow_out;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");
  property p_clear;
    disable iff (!rst_n_in) clr_wr && !checker_byte_valid_in
      |=> checker_byte_total_out == 16'h0000 && !checker_byte_total_overflow_out;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero the counter");
  property p_idle_exit;
    disable iff (!rst_n_in) symbol_valid_in && !symbol_idle_in |=> !idle_mode_out;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle mode kept after data symbol");
  property p_idle_enter;
    disable iff (!rst_n_in) $rose(idle_mode_out) |-> $past(symbol_valid_in && symbol_idle_in);
  endproperty
  a_idle_enter: assert property (p_idle_enter) else $error("idle mode without idle symbol");
  property p_strap_hold;
    disable iff (!rst_n_in) strap_valid_out |=> strap_valid_out && $stable(strap_held_out);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("captured straps changed");
endmodule

bind phy_misc_status_config_regs phy_misc_status_config_regs_checker checker_i (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .symbol_valid_in(symbol_valid_in),
  .symbol_idle_in(symbol_idle_in), .checker_byte_valid_in(checker_byte_valid_in),
  .idle_mode_out(idle_mode_out), .idle_symbol_threshold_out(idle_symbol_threshold_out),
  .strap_held_out(strap_held_out), .strap_valid_out(strap_valid_out),
  .checker_byte_total_out(checker_byte_total_out),
  .checker_byte_total_overflow_out(checker_byte_total_overflow_out)
);
`default_nettype wire

//--- tb/phy_misc_status_config_regs_test.sv
// Self-checking bench of the misc register bank driven over APB.
`timescale 1ns/1ps
`default_nettype none

module phy_misc_status_config_regs_test;
  logic ref_clk_in, rst_n_in, psel, penable, pwrite, sym_v, sym_i, byte_v;
  logic pready, pslverr, idle_mode, ovf, strap_valid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] chan_a, chan_b, thr;
  logic [15:0] total;
  logic e;
  phy_misc_pkg::strap_pins_s sp, pins, held;
  int miscompares, checked, n;

  phy_misc_status_config_regs dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .strap_pins_in(pins), .symbol_valid_in(sym_v),
    .symbol_idle_in(sym_i), .chan_a_alignment_cycles_in(chan_a), .chan_b_alignment_cycles_in(chan_b),
    .checker_byte_valid_in(byte_v), .idle_mode_out(idle_mode), .idle_symbol_threshold_out(thr),
    .strap_held_out(held), .strap_valid_out(strap_valid), .checker_byte_total_out(total),
    .checker_byte_total_overflow_out(ovf)
  );

  // Free running clock at 200 MHz.
  initial begin
    ref_clk_in = 1'b0;
    forever #2.5 ref_clk_in = ~ref_clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops the run.
  task automatic summarize;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until ready is seen at an edge.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk_in);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      summarize();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a register and compares it with the expected word.
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h00000000);
    chk(r, exp);
  endtask

  // Sends one symbol pulse, idle or not.
  task automatic sym(input logic idle);
    @(posedge ref_clk_in);
    sym_v <= 1'b1;
    sym_i <= idle;
    @(posedge ref_clk_in);
    sym_v <= 1'b0;
  endtask

  // Holds the byte strobe for the given number of cycles.
  task automatic bytes(input int cnt);
    @(posedge ref_clk_in);
    byte_v <= 1'b1;
    repeat (cnt) @(posedge ref_clk_in);
    byte_v <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence of tests.
  initial begin
    sp = 21'h16B59C;
    pins = sp;
    rst_n_in = 1'b0;
    {psel, penable, pwrite, sym_v, sym_i, byte_v} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    chan_a = 4'h9;
    chan_b = 4'h6;
    repeat (10) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    n = 0;
    while (strap_valid !== 1'b1 && n < 20) begin
      @(posedge ref_clk_in);
      n++;
    end
    chk({31'h0, strap_valid}, 32'h00000001);
    // A capture that never comes ends the run at once.
    if (strap_valid !== 1'b1) begin
      summarize();
    end
    rd(12'h14C, 32'h00002055);
    rd(12'h1C4, 32'h00000000);
    rd(12'h000, 32'h00000000);
    chk({31'h0, e}, 32'h00000001);
    rd(12'h154, 32'h00000069);
    $display("reset and map test done");
    pins <= ~sp;
    xfer(1'b1, 12'h1B8, 32'h0000FFFF);
    rd(12'h1B8, {16'h0, sp[20:12], 1'b0, sp.autoneg_select, 1'b0, sp.mgmt_address});
    rd(12'h1BC, {21'h0, sp.fast_link_drop, 3'h0, sp.tx_clock_delay, 1'b0, sp.rx_clock_delay});
    chk({11'h0, held}, {11'h0, sp});
    $display("strap test done");
    xfer(1'b1, 12'h14C, 32'h0000FFF4);
    rd(12'h14C, 32'h00002054);
    chk({28'h0, thr}, 32'h00000004);
    repeat (3) sym(1'b1);
    #1 chk({31'h0, idle_mode}, 32'h00000000);
    sym(1'b1);
    #1 chk({31'h0, idle_mode}, 32'h00000001);
    sym(1'b0);
    #1 chk({31'h0, idle_mode}, 32'h00000000);
    $display("idle test done");
    bytes(10);
    xfer(1'b1, 12'h1C8, 32'h00000001);
    rd(12'h1C4, 32'h0000000A);
    bytes(5);
    rd(12'h1C4, 32'h0000000A);
    chk({16'h0, total}, 32'h0000000F);
    bytes(65520);
    #1 chk({15'h0, ovf, total}, 32'h0000FFFF);
    bytes(2);
    #1 chk({15'h0, ovf, total}, 32'h0001FFFF);
    rd(12'h1C8, 32'h00000200);
    // Wrap select set: the counter rolls over to zero and keeps counting.
    xfer(1'b1, 12'h1F8, 32'h00000001);
    rd(12'h1F8, 32'h00000001);
    bytes(4);
    #1 chk({15'h0, ovf, total}, 32'h00010003);
    xfer(1'b1, 12'h1C8, 32'h00000002);
    rd(12'h1C4, 32'h00000003);
    rd(12'h1C8, 32'h00000000);
    chk({15'h0, ovf, total}, 32'h00000000);
    $display("byte counter test done");
    summarize();
  end
endmodule
`default_nettype wire
